/* dcpb_pkg.sv */
// Package for the drive control parameter bank: offsets, fields, codes
`default_nettype none
package dcpb_pkg;
    // Register offsets (fieldbus parameter addresses)
    localparam logic [15:0] OFF_IN0_DEB = 16'h0840;
    localparam logic [15:0] OFF_IN1_DEB = 16'h0842;
    localparam logic [15:0] OFF_IN2_DEB = 16'h0844;
    localparam logic [15:0] OFF_IN3_DEB = 16'h0846;
    localparam logic [15:0] OFF_CTRL_WORD = 16'h1b02;
    localparam logic [15:0] OFF_OP_MODE = 16'h1b06;
    localparam logic [15:0] OFF_PROF_ACT = 16'h1b10;
    localparam logic [15:0] OFF_PROF_MOTION = 16'h1b3e;
    // Reset values
    localparam logic [15:0] RST_DEB = 16'h0006;
    localparam logic [15:0] RST_CTRL_WORD = 16'h0000;
    localparam logic [15:0] RST_OP_MODE = 16'h0000;
    localparam logic [15:0] RST_PROF_ACT = 16'h0000;
    localparam logic [15:0] RST_PROF_MOTION = 16'h0000;
    // Control word bit positions
    localparam int CW_SWITCH_ON = 0;
    localparam int CW_ENABLE_VOLTAGE = 1;
    localparam int CW_QUICK_STOP = 2;
    localparam int CW_ENABLE_OP = 3;
    localparam int CW_MODE_LO = 4;
    localparam int CW_MODE_HI = 6;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_HALT = 8;
    localparam int CW_MODE_B9 = 9;
    localparam logic [15:0] CW_RESERVED_MASK = 16'hfc00;
    // Operating mode codes (signed)
    localparam logic signed [15:0] MODE_TUNING = -16'sd6;
    localparam logic signed [15:0] MODE_JOG = -16'sd1;
    localparam logic signed [15:0] MODE_RESERVED = 16'sd0;
    localparam logic signed [15:0] MODE_PROF_POS = 16'sd1;
    localparam logic signed [15:0] MODE_PROF_VEL = 16'sd3;
    localparam logic signed [15:0] MODE_PROF_TRQ = 16'sd4;
    localparam logic signed [15:0] MODE_HOMING = 16'sd6;
    localparam logic signed [15:0] MODE_INTERP_POS = 16'sd7;
    localparam logic signed [15:0] MODE_CSP = 16'sd8;
    localparam logic signed [15:0] MODE_CSV = 16'sd9;
    localparam logic signed [15:0] MODE_CST = 16'sd10;
    // Debounce
    localparam logic [15:0] DEB_MAX_CODE = 16'h0006;
    localparam int DEB_STEP_NS = 250000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEB_STEP_CYC = DEB_STEP_NS / CLK_PERIOD_NS;
    localparam int DEB_CNT_W = 18;
    // Access channels
    localparam logic [1:0] CH_NONE = 2'h0;
    localparam logic [1:0] CH_CANOPEN = 2'h1;
    localparam logic [1:0] CH_MODBUS = 2'h2;

    typedef enum logic [1:0] {DCPB_CH_CANOPEN, DCPB_CH_MODBUS} dcpb_chan_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] chan;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dcpb_req_type;

    typedef struct packed {
        logic switch_on;
        logic enable_voltage;
        logic quick_stop;
        logic enable_operation;
        logic fault_reset;
        logic halt;
        logic [3:0] mode_bits;
    } dcpb_cmd_type;

    typedef enum logic [3:0] {
        DCPB_M_TUNING, DCPB_M_JOG, DCPB_M_NONE, DCPB_M_PPOS, DCPB_M_PVEL, DCPB_M_PTRQ,
        DCPB_M_HOME, DCPB_M_IPOS, DCPB_M_CSP, DCPB_M_CSV, DCPB_M_CST, DCPB_M_BAD
    } dcpb_mode_type;
endpackage : dcpb_pkg
`default_nettype wire

/* dcpb_debounce.sv */
// Single input debouncer with a selectable hold time
`default_nettype none
module dcpb_debounce #(
    parameter int STEP_CYC = dcpb_pkg::DEB_STEP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic raw_in,
    input wire logic [2:0] sel,
    output logic filt_out
);
    import dcpb_pkg::*;

    logic [DEB_CNT_W-1:0] cnt_r;
    logic [DEB_CNT_W-1:0] limit;

    assign limit = DEB_CNT_W'(STEP_CYC * int'(sel));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (raw_in == filt_out || sel == 3'h0) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + DEB_CNT_W'(1);
        end
    end

    // With a nonzero code, output moves only after raw level held for the full time; code zero follows raw each cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            filt_out <= 1'b0;
        end else if (sel == 3'h0) begin
            filt_out <= raw_in;
        end else if (raw_in != filt_out && cnt_r + DEB_CNT_W'(1) >= limit) begin
            filt_out <= raw_in;
        end
    end
endmodule : dcpb_debounce
`default_nettype wire

/* dcpb_bank.sv */
// Drive control parameter bank: control word, mode, debounce, profile owner
`default_nettype none
//
// Contract
// - Bits 0-3 drive state machine commands
// - Bit 7 fault reset, bit 8 halt
// - Bits 4-6 and 9 mode dependent
// - Control word and mode apply immediately
// - Mode codes -6,-1,0,1,3,4 decoded
// - Mode codes 6,7,8 and cyclic modes
// - Mode is INT8 over CANopen, INT16 otherwise
// - Debounce code 1-6 gives 0.25 ms steps
// - Debounce code zero passes input through
// - Debounce change only while power stage off
// - Profile activation: 0 off, 1 on
// - Only activating channel may use profile
module dcpb_bank #(
    parameter int NUM_IN = 4,
    parameter int STEP_CYC = dcpb_pkg::DEB_STEP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire dcpb_pkg::dcpb_req_type req,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic wr_err,
    input wire logic power_stage_on,
    input wire logic [NUM_IN-1:0] digital_input_raw,
    output logic [NUM_IN-1:0] digital_input_filt,
    output dcpb_pkg::dcpb_cmd_type drive_cmd,
    output dcpb_pkg::dcpb_mode_type op_mode,
    output logic profile_active,
    output logic [1:0] profile_owner,
    output logic [15:0] profile_motion_out
);
    import dcpb_pkg::*;

    logic [15:0] drive_control_word_r;
    logic [15:0] operating_mode_select_r;
    logic [15:0] deb_r [NUM_IN];
    logic profile_activation_r;
    logic [1:0] owner_r;
    logic [15:0] profile_motion_control_r;
    logic [15:0] mode_wval;
    logic [15:0] rd_nxt;
    logic hit_known;
    logic prof_ok;
    logic deb_hit;
    logic [1:0] deb_idx;

    function automatic dcpb_mode_type decode_mode(input logic [15:0] code);
        case ($signed(code))
            MODE_TUNING: decode_mode = DCPB_M_TUNING;
            MODE_JOG: decode_mode = DCPB_M_JOG;
            MODE_RESERVED: decode_mode = DCPB_M_NONE;
            MODE_PROF_POS: decode_mode = DCPB_M_PPOS;
            MODE_PROF_VEL: decode_mode = DCPB_M_PVEL;
            MODE_PROF_TRQ: decode_mode = DCPB_M_PTRQ;
            MODE_HOMING: decode_mode = DCPB_M_HOME;
            MODE_INTERP_POS: decode_mode = DCPB_M_IPOS;
            MODE_CSP: decode_mode = DCPB_M_CSP;
            MODE_CSV: decode_mode = DCPB_M_CSV;
            MODE_CST: decode_mode = DCPB_M_CST;
            default: decode_mode = DCPB_M_BAD;
        endcase
    endfunction : decode_mode

    function automatic logic is_prof_reg(input logic [15:0] a);
        is_prof_reg = (a == OFF_PROF_MOTION);
    endfunction : is_prof_reg

    // CANopen carries the mode as INT8; sign extend to the 16-bit form
    always_comb begin
        if (req.chan == CH_CANOPEN) begin
            mode_wval = {{8{req.wdata[7]}}, req.wdata[7:0]};
        end else begin
            mode_wval = req.wdata;
        end
    end

    always_comb begin
        deb_hit = 1'b0;
        deb_idx = 2'h0;
        case (req.addr)
            OFF_IN0_DEB: begin
                deb_hit = 1'b1;
                deb_idx = 2'h0;
            end
            OFF_IN1_DEB: begin
                deb_hit = 1'b1;
                deb_idx = 2'h1;
            end
            OFF_IN2_DEB: begin
                deb_hit = 1'b1;
                deb_idx = 2'h2;
            end
            OFF_IN3_DEB: begin
                deb_hit = 1'b1;
                deb_idx = 2'h3;
            end
            default: begin
                deb_hit = 1'b0;
                deb_idx = 2'h0;
            end
        endcase
    end

    // Profile registers are usable only by the owning channel
    assign prof_ok = profile_activation_r && (owner_r == req.chan);

    // Control word: reserved bits are the master's duty, stored as written
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            drive_control_word_r <= RST_CTRL_WORD;
        end else if (req.wr && req.addr == OFF_CTRL_WORD) begin
            drive_control_word_r <= req.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            operating_mode_select_r <= RST_OP_MODE;
        end else if (req.wr && req.addr == OFF_OP_MODE) begin
            operating_mode_select_r <= mode_wval;
        end
    end

    // Out-of-range codes are refused rather than clamped
    generate
        for (genvar g = 0; g < NUM_IN; g++) begin : g_deb
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    deb_r[g] <= RST_DEB;
                end else if (req.wr && deb_hit && deb_idx == 2'(g) && !power_stage_on
                             && req.wdata <= DEB_MAX_CODE) begin
                    deb_r[g] <= req.wdata;
                end
            end

            dcpb_debounce #(
                .STEP_CYC(STEP_CYC)
            ) u_deb (
                .mclk(mclk),
                .rst(rst),
                .raw_in(digital_input_raw[g]),
                .sel(deb_r[g][2:0]),
                .filt_out(digital_input_filt[g])
            );
        end
    endgenerate

    // Activation claims ownership; another channel cannot steal or drop it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            profile_activation_r <= 1'b0;
            owner_r <= CH_NONE;
        end else if (req.wr && req.addr == OFF_PROF_ACT
                     && (!profile_activation_r || owner_r == req.chan)) begin
            if (req.wdata == 16'h0001) begin
                profile_activation_r <= 1'b1;
                owner_r <= req.chan;
            end else if (req.wdata == 16'h0000) begin
                profile_activation_r <= 1'b0;
                owner_r <= CH_NONE;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            profile_motion_control_r <= RST_PROF_MOTION;
        end else if (req.wr && is_prof_reg(req.addr) && prof_ok) begin
            profile_motion_control_r <= req.wdata;
        end
    end

    always_comb begin
        rd_nxt = 16'h0000;
        hit_known = 1'b1;
        if (deb_hit) begin
            rd_nxt = deb_r[deb_idx];
        end else begin
            case (req.addr)
                OFF_CTRL_WORD: rd_nxt = drive_control_word_r;
                OFF_OP_MODE: begin
                    if (req.chan == CH_CANOPEN) begin
                        rd_nxt = {{8{operating_mode_select_r[7]}},
                                  operating_mode_select_r[7:0]};
                    end else begin
                        rd_nxt = operating_mode_select_r;
                    end
                end
                OFF_PROF_ACT: rd_nxt = {15'h0000, profile_activation_r};
                OFF_PROF_MOTION: rd_nxt = prof_ok ? profile_motion_control_r : 16'h0000;
                default: hit_known = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rdata <= req.rd ? rd_nxt : 16'h0000;
            rvalid <= req.rd;
        end
    end

    // Flags refused writes: unknown address, locked debounce, bad code, foreign channel
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_err <= 1'b0;
        end else begin
            wr_err <= (req.wr || req.rd) && (!hit_known
                || (req.wr && deb_hit && (power_stage_on || req.wdata > DEB_MAX_CODE))
                || (req.wr && req.addr == OFF_PROF_ACT && req.wdata > 16'h0001)
                || (req.wr && req.addr == OFF_PROF_ACT && profile_activation_r
                    && owner_r != req.chan)
                || (is_prof_reg(req.addr) && !prof_ok));
        end
    end

    // Drive commands decoded from the live control word
    always_comb begin
        drive_cmd.switch_on = drive_control_word_r[CW_SWITCH_ON];
        drive_cmd.enable_voltage = drive_control_word_r[CW_ENABLE_VOLTAGE];
        drive_cmd.quick_stop = drive_control_word_r[CW_QUICK_STOP];
        drive_cmd.enable_operation = drive_control_word_r[CW_ENABLE_OP];
        drive_cmd.fault_reset = drive_control_word_r[CW_FAULT_RESET];
        drive_cmd.halt = drive_control_word_r[CW_HALT];
        drive_cmd.mode_bits = {drive_control_word_r[CW_MODE_B9],
                               drive_control_word_r[CW_MODE_HI:CW_MODE_LO]};
    end

    assign op_mode = decode_mode(operating_mode_select_r);
    assign profile_active = profile_activation_r;
    assign profile_owner = owner_r;
    assign profile_motion_out = profile_motion_control_r;
endmodule : dcpb_bank
`default_nettype wire

/* dcpb_bank_assertions.sv */
// Concurrent checks on the parameter bank ports
`default_nettype none
module dcpb_bank_assertions #(
    parameter int NUM_IN = 4,
    parameter int STEP_CYC = dcpb_pkg::DEB_STEP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire dcpb_pkg::dcpb_req_type req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic wr_err,
    input wire logic power_stage_on,
    input wire logic [NUM_IN-1:0] digital_input_raw,
    input wire logic [NUM_IN-1:0] digital_input_filt,
    input wire dcpb_pkg::dcpb_cmd_type drive_cmd,
    input wire dcpb_pkg::dcpb_mode_type op_mode,
    input wire logic profile_active,
    input wire logic [1:0] profile_owner,
    input wire logic [15:0] profile_motion_out
);
    import dcpb_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic cw_wr = req.wr && req.addr == OFF_CTRL_WORD;
    wire logic md_wr = req.wr && req.addr == OFF_OP_MODE;
    a_cmd_low_bits:
    assert property (cw_wr |=> {drive_cmd.enable_operation, drive_cmd.quick_stop,
        drive_cmd.enable_voltage, drive_cmd.switch_on} == $past(req.wdata[3:0]))
    else $error("state commands differ from written word");
    a_cmd_fault_halt:
    assert property (cw_wr |=> drive_cmd.fault_reset == $past(req.wdata[7])
        && drive_cmd.halt == $past(req.wdata[8])) else $error("fault reset or halt wrong");
    a_cmd_mode_bits:
    assert property (cw_wr |=> drive_cmd.mode_bits == {$past(req.wdata[9]), $past(req.wdata[6:4])})
    else $error("mode specific bits wrong");
    a_mode_jog_code:
    assert property (md_wr && req.chan == CH_MODBUS && req.wdata == 16'hffff
        |=> op_mode == DCPB_M_JOG) else $error("jog code not decoded");
    a_mode_homing_code:
    assert property (md_wr && req.chan == CH_MODBUS && req.wdata == 16'h0006
        |=> op_mode == DCPB_M_HOME) else $error("homing code not decoded");
    a_mode_byte_wide:
    assert property (md_wr && req.chan == CH_CANOPEN && req.wdata[7:0] == 8'hfa
        |=> op_mode == DCPB_M_TUNING) else $error("byte wide mode not sign extended");
    a_deb_locked:
    assert property (req.wr && power_stage_on && req.addr[15:3] == 13'h108 |=> wr_err)
    else $error("selector write accepted with power stage on");
    a_act_bad_value:
    assert property (req.wr && req.addr == OFF_PROF_ACT && req.wdata > 16'h0001
        |=> wr_err && $stable(profile_active)) else $error("bad activation value taken");
    a_owner_only:
    assert property (profile_active && req.wr && req.chan != profile_owner
        && (req.addr == OFF_PROF_ACT || req.addr == OFF_PROF_MOTION)
        |=> wr_err && $stable(profile_motion_out)) else $error("foreign channel used profile");
    // A filtered bit may only move to a level the raw input already held
    a_filt_settled:
    assert property (((digital_input_filt ^ $past(digital_input_filt))
        & (digital_input_filt ^ $past(digital_input_raw))) == '0)
    else $error("filtered input moved to unsettled level");
    c_ctrl_write: cover property (cw_wr);
    c_foreign: cover property (profile_active && req.wr && req.chan != profile_owner);
    c_filt_rise: cover property ($rose(digital_input_filt[0]));
endmodule : dcpb_bank_assertions
`default_nettype wire

/* dcpb_master.sv */
// Fieldbus master model issuing parameter reads and writes
`default_nettype none
module dcpb_master (
    input wire logic mclk,
    output dcpb_pkg::dcpb_req_type req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic wr_err
);
    import dcpb_pkg::*;
    initial req = '0;
    task automatic xfer(input logic w, input logic [1:0] ch, input logic [15:0] a,
        input logic [15:0] d, output logic [15:0] rd, output logic [1:0] fl);
        logic [15:0] dd;
        dd = d;
        if (a == OFF_CTRL_WORD) dd = d & ~CW_RESERVED_MASK;
        // CANopen carries only the mode's low byte; the bank must widen it
        if (ch == CH_CANOPEN && a == OFF_OP_MODE) dd = {8'h00, d[7:0]};
        @(posedge mclk);
        req <= '{wr: w, rd: !w, chan: ch, addr: a, wdata: dd};
        @(posedge mclk);
        // Released strobes drop to zero; chan, addr and wdata show inverted values, never the stale ones
        req <= '{wr: 1'b0, rd: 1'b0, chan: ~ch, addr: ~a, wdata: ~dd};
        #1;
        rd = rdata;
        fl = {rvalid, wr_err};
    endtask : xfer
endmodule : dcpb_master
`default_nettype wire

/* test_dcpb_bank.sv */
// Self-checking bench for the drive control parameter bank
`default_nettype none
module test_dcpb_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import dcpb_pkg::*;
    localparam int STEP = 4;
    typedef struct packed {
        logic [1:0] ch;
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] x;
        logic e;
    } dcpb_row_type;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic power_stage_on = 1'b0;
    logic [3:0] digital_input_raw = 4'h0;
    logic [3:0] digital_input_filt;
    dcpb_req_type req;
    logic [15:0] rdata, profile_motion_out, rd;
    logic rvalid, wr_err, profile_active;
    logic [1:0] profile_owner, fl;
    dcpb_cmd_type drive_cmd;
    dcpb_mode_type op_mode;
    int err_count = 0;
    int checks_done = 0;
    dcpb_row_type rows [13] = '{
        '{CH_MODBUS, OFF_CTRL_WORD, 16'h038f, 16'h038f, 1'b0},
        '{CH_MODBUS, OFF_OP_MODE, 16'hfffa, 16'hfffa, 1'b0},
        '{CH_CANOPEN, OFF_OP_MODE, 16'h00fa, 16'hfffa, 1'b0},
        '{CH_MODBUS, OFF_IN0_DEB, 16'h0003, 16'h0003, 1'b0},
        '{CH_MODBUS, OFF_IN1_DEB, 16'h0007, 16'h0006, 1'b1},
        '{CH_MODBUS, OFF_IN2_DEB, 16'h0000, 16'h0000, 1'b0},
        '{CH_MODBUS, OFF_PROF_ACT, 16'h0002, 16'h0000, 1'b1},
        '{CH_CANOPEN, OFF_PROF_ACT, 16'h0001, 16'h0001, 1'b0},
        '{CH_MODBUS, OFF_PROF_ACT, 16'h0000, 16'h0001, 1'b1},
        '{CH_CANOPEN, OFF_PROF_MOTION, 16'h1234, 16'h1234, 1'b0},
        '{CH_MODBUS, OFF_PROF_MOTION, 16'h5555, 16'h0000, 1'b1},
        '{CH_CANOPEN, OFF_PROF_ACT, 16'h0000, 16'h0000, 1'b0},
        '{CH_MODBUS, OFF_IN3_DEB, 16'h0006, 16'h0006, 1'b0}};
    logic [15:0] mcode [12] = '{MODE_TUNING, MODE_JOG, MODE_RESERVED, MODE_PROF_POS,
        MODE_PROF_VEL, MODE_PROF_TRQ, MODE_HOMING, MODE_INTERP_POS, MODE_CSP, MODE_CSV,
        MODE_CST, 16'h0002};
    dcpb_mode_type mexp [12] = '{DCPB_M_TUNING, DCPB_M_JOG, DCPB_M_NONE, DCPB_M_PPOS,
        DCPB_M_PVEL, DCPB_M_PTRQ, DCPB_M_HOME, DCPB_M_IPOS, DCPB_M_CSP, DCPB_M_CSV, DCPB_M_CST,
        DCPB_M_BAD};
    always #5 mclk = ~mclk;
    dcpb_master m (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid), .wr_err(wr_err));
    dcpb_bank #(.NUM_IN(4), .STEP_CYC(STEP)) uut (.mclk(mclk), .rst(rst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .wr_err(wr_err), .power_stage_on(power_stage_on),
        .digital_input_raw(digital_input_raw), .digital_input_filt(digital_input_filt),
        .drive_cmd(drive_cmd), .op_mode(op_mode), .profile_active(profile_active),
        .profile_owner(profile_owner), .profile_motion_out(profile_motion_out));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            m.xfer(1'b1, rows[i].ch, rows[i].a, rows[i].d, rd, fl);
            chk("wr_err", {15'h0, fl[0]}, {15'h0, rows[i].e});
            m.xfer(1'b0, rows[i].ch, rows[i].a, 16'h0, rd, fl);
            chk("rdata", rd, rows[i].x);
        end
        foreach (mcode[i]) begin
            m.xfer(1'b1, CH_MODBUS, OFF_OP_MODE, mcode[i], rd, fl);
            chk("op_mode", {12'h0, op_mode}, {12'h0, mexp[i]});
        end
        m.xfer(1'b1, CH_MODBUS, OFF_CTRL_WORD, 16'h02d5, rd, fl);
        chk("drive_cmd", {6'h0, drive_cmd}, 16'h02ad);
        m.xfer(1'b1, CH_MODBUS, OFF_PROF_ACT, 16'h0001, rd, fl);
        chk("owner", {14'h0, profile_owner}, {14'h0, CH_MODBUS});
        chk("active", {15'h0, profile_active}, 16'h0001);
        chk("motion", profile_motion_out, 16'h1234);
        m.xfer(1'b1, CH_MODBUS, OFF_PROF_ACT, 16'h0000, rd, fl);
        chk("release", {13'h0, profile_active, profile_owner}, 16'h0000);
        m.xfer(1'b1, CH_MODBUS, OFF_PROF_MOTION, 16'h5555, rd, fl);
        chk("idle motion", profile_motion_out, 16'h1234);
        chk("idle err", {15'h0, fl[0]}, 16'h0001);
        m.xfer(1'b1, CH_MODBUS, OFF_IN0_DEB, 16'h0001, rd, fl);
        @(posedge mclk) digital_input_raw <= 4'h5;
        repeat (2) @(posedge mclk);
        #1 chk("filt early", {12'h0, digital_input_filt}, 16'h0004);
        repeat (STEP + 1) @(posedge mclk);
        #1 chk("filt late", {12'h0, digital_input_filt}, 16'h0005);
        @(posedge mclk) digital_input_raw <= 4'h4;
        @(posedge mclk) digital_input_raw <= 4'h5;
        repeat (STEP + 2) @(posedge mclk);
        #1 chk("filt glitch", {12'h0, digital_input_filt}, 16'h0005);
        @(posedge mclk) power_stage_on <= 1'b1;
        m.xfer(1'b1, CH_MODBUS, OFF_IN0_DEB, 16'h0005, rd, fl);
        chk("locked err", {14'h0, fl}, 16'h0001);
        m.xfer(1'b0, CH_MODBUS, OFF_IN0_DEB, 16'h0, rd, fl);
        chk("locked rd", rd, 16'h0001);
        chk("rvalid", {14'h0, fl}, 16'h0002);
        @(posedge mclk) power_stage_on <= 1'b0;
        m.xfer(1'b1, CH_MODBUS, 16'h0900, 16'h0001, rd, fl);
        chk("unmapped", {14'h0, fl}, 16'h0001);
        @(posedge mclk) rst <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("filt rst", {12'h0, digital_input_filt}, 16'h0000);
        rst <= 1'b0;
        m.xfer(1'b0, CH_MODBUS, OFF_IN0_DEB, 16'h0, rd, fl);
        chk("sel rst", rd, RST_DEB);
        m.xfer(1'b0, CH_MODBUS, OFF_PROF_ACT, 16'h0, rd, fl);
        chk("act rst", rd, RST_PROF_ACT);
        wrap_up();
    end
endmodule : test_dcpb_bank
bind dcpb_bank dcpb_bank_assertions #(.NUM_IN(NUM_IN), .STEP_CYC(STEP_CYC)) chk_i (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .wr_err(wr_err),
    .power_stage_on(power_stage_on), .digital_input_raw(digital_input_raw),
    .digital_input_filt(digital_input_filt), .drive_cmd(drive_cmd), .op_mode(op_mode),
    .profile_active(profile_active), .profile_owner(profile_owner),
    .profile_motion_out(profile_motion_out));
`default_nettype wire
